// >>> pkg/icw_pkg.sv
/*
  package for the identify capability words block: word numbers, avalon
  offsets, field positions, encodings and reset values.
  assumes one 100 MHz clock and an avalon-mm master with waitrequest.
*/
// Behaviour
// - at most one dma mode selected
// - bits 13..8 flag udma mode 5..0 selected
// - udma support flags are cumulative downwards
// - udma word present whenever udma supported
// - erase time: 0 unspecified, n*2 min, 255 long
// - enhanced erase time uses same encoding
// - word 91 low byte is current apm level
// - bit 8 set means maximum security level
// - expired count aborts unlock and erase commands
// - security status bits 5,3,2,1,0 report state
// - power word: valid, reserved zero, max current
// - bits 13/12: level1 commands absent / disabled
// - key word bit 0 content protection, rest zero
// - bits 2-0 maximum advanced pio mode
// - bits 5-3 maximum advanced mwdma mode
// - bits 8-6 selected advanced pio mode
// - bits 11-9 selected mwdma mode, 15-12 zero
// - pc card io cycle code in bits 2-0
// - pc card memory cycle code in bits 5-3
package icw_pkg;
  // identify word numbers served
  localparam logic [7:0] ICW_W_UDMA = 8'h58; // word 88
  localparam logic [7:0] ICW_W_ERASE = 8'h59;
  localparam logic [7:0] ICW_W_EERASE = 8'h5a;
  localparam logic [7:0] ICW_W_APM = 8'h5b;
  localparam logic [7:0] ICW_W_SEC = 8'h80; // word 128
  localparam logic [7:0] ICW_W_POWER = 8'ha0; // word 160
  localparam logic [7:0] ICW_W_KEY = 8'ha2;
  localparam logic [7:0] ICW_W_ADVIDE = 8'ha3;
  localparam logic [7:0] ICW_W_PCCARD = 8'ha4;
  // avalon word offsets
  localparam logic [3:0] ICW_A_WORDSEL = 4'h0; // identify word number (rw)
  localparam logic [3:0] ICW_A_WORDDATA = 4'h1; // selected word (ro)
  localparam logic [3:0] ICW_A_XFER = 4'h2; // transfer mode select (rw)
  localparam logic [3:0] ICW_A_SEC = 4'h3; // security control (rw)
  localparam logic [3:0] ICW_A_APM = 4'h4; // apm level (rw)
  localparam logic [3:0] ICW_A_CMD = 4'h5; // security command check (wo)
  localparam logic [3:0] ICW_A_STAT = 4'h6; // command verdict (ro)
  localparam logic [3:0] ICW_A_CAP = 4'h7; // erase times, current (rw)
  // xfer register fields
  localparam int ICW_XF_KIND_LSB = 4; // 0 none/pio, 1 udma, 2 mwdma
  localparam int ICW_XF_MODE_LSB = 0; // mode number
  localparam logic [1:0] ICW_KIND_PIO = 2'h0;
  localparam logic [1:0] ICW_KIND_UDMA = 2'h1;
  localparam logic [1:0] ICW_KIND_MWDMA = 2'h2;
  // security control bits
  localparam int ICW_SC_EN = 0;
  localparam int ICW_SC_LOCK = 1;
  localparam int ICW_SC_FROZEN = 2;
  localparam int ICW_SC_MAX = 3;
  localparam int ICW_SC_EXPIRE = 4; // write 1 sets, cleared only by reset
  // security commands checked by ICW_A_CMD
  localparam logic [1:0] ICW_CMD_UNLOCK = 2'h1;
  localparam logic [1:0] ICW_CMD_ERASE = 2'h2;
  // reset values
  localparam logic [7:0] ICW_APM_RST = 8'h80;
  localparam logic [7:0] ICW_ERASE_RST = 8'h00;
  localparam logic [11:0] ICW_CUR_RST = 12'h000;
  // advanced timing encodings
  localparam logic [2:0] ICW_ADV_OLDER = 3'h0;
  localparam logic [2:0] ICW_ADV_MODE_A = 3'h1; // pio 5 / mwdma 3
  localparam logic [2:0] ICW_ADV_MODE_B = 3'h2; // pio 6 / mwdma 4
  localparam logic [2:0] ICW_PC_80NS = 3'h3;
  // avalon request carrier
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } icw_av_req_type;
endpackage : icw_pkg

// >>> verilog/icw_identify_words.sv
/*
  identify capability words 88..164 served over avalon-mm, with the
  transfer mode, security, apm and erase time state that feeds them.
  assumes the master holds a request until waitrequest is seen low;
  this slave answers every access one cycle after it is presented.
*/
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module icw_identify_words
  import icw_pkg::*;
#(
  parameter int UDMA_MAX = 5, // highest udma mode supported, -1 none
  parameter bit KEY_SCHEME = 1'b0,
  parameter logic [2:0] PIO_MAX_ADV = 3'h2,
  parameter logic [2:0] MW_MAX_ADV = 3'h2,
  parameter logic [2:0] PC_IO_CODE = 3'h3,
  parameter logic [2:0] PC_MEM_CODE = 3'h3,
  parameter bit LEVEL1_ABSENT = 1'b1,
  parameter bit ENH_ERASE = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire icw_av_req_type av_req,
  output logic av_waitrequest,
  output logic [31:0] av_readdata
);
  initial begin
    if (UDMA_MAX > 5 || UDMA_MAX < -1) $error("UDMA_MAX out of range");
    if (PIO_MAX_ADV > 3'h2 || MW_MAX_ADV > 3'h2) $error("reserved adv code");
    if (PC_IO_CODE > 3'h3 || PC_MEM_CODE > 3'h3) $error("reserved pc code");
  end

  logic [7:0] wordsel_ff;
  logic [1:0] kind_ff;
  logic [2:0] mode_ff;
  logic [4:0] sec_ff;
  logic [7:0] apm_ff;
  logic [7:0] erase_ff;
  logic [7:0] eerase_ff;
  logic [11:0] cur_ff;
  logic [1:0] verdict_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;

  // one wait cycle per access keeps read data registered
  wire logic req = av_req.read | av_req.write;
  wire logic take = req & ~ack_ff;
  wire logic do_wr = take & av_req.write;
  assign av_waitrequest = req & ~ack_ff;
  assign av_readdata = rdata_ff;

  // cumulative support mask, bits 0 up to the given top mode set
  function automatic logic [5:0] icw_thermo(input int top);
    logic [5:0] m;
    m = 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (i <= top) m[i] = 1'b1;
    end
    return m;
  endfunction : icw_thermo

  // reject a mode the card cannot serve so one dma select stays valid
  wire logic [1:0] wr_kind = av_req.writedata[ICW_XF_KIND_LSB +: 2];
  wire logic [2:0] wr_mode = av_req.writedata[ICW_XF_MODE_LSB +: 3];
  wire logic wr_mode_ok = (wr_kind == ICW_KIND_PIO) ||
    (wr_kind == ICW_KIND_UDMA && int'(wr_mode) <= UDMA_MAX) ||
    (wr_kind == ICW_KIND_MWDMA && wr_mode <= 3'h4);

  // word 88
  wire logic [5:0] udma_sup = icw_thermo(UDMA_MAX);
  wire logic [5:0] udma_sel = (kind_ff == ICW_KIND_UDMA) ?
    6'(6'h01 << mode_ff) : 6'h00;
  wire logic [15:0] w_udma = {2'b00, udma_sel, 2'b00, udma_sup};

  // word 128
  wire logic sec_en = sec_ff[ICW_SC_EN];
  wire logic [15:0] w_sec = {7'h00, sec_en & sec_ff[ICW_SC_MAX], 2'b00,
    ENH_ERASE, sec_ff[ICW_SC_EXPIRE], sec_ff[ICW_SC_FROZEN],
    sec_ff[ICW_SC_LOCK], sec_en, 1'b1};

  // word 160: level1 commands disabled whenever absent
  wire logic [15:0] w_pow = {1'b1, 1'b0, LEVEL1_ABSENT, LEVEL1_ABSENT,
    cur_ff};

  // word 163: selected advanced modes follow the transfer select
  wire logic [2:0] pio_sel = (kind_ff == ICW_KIND_PIO && mode_ff == 3'h5) ?
    ICW_ADV_MODE_A : (kind_ff == ICW_KIND_PIO && mode_ff == 3'h6) ?
    ICW_ADV_MODE_B : ICW_ADV_OLDER;
  wire logic [2:0] mw_sel = (kind_ff == ICW_KIND_MWDMA && mode_ff == 3'h3) ?
    ICW_ADV_MODE_A : (kind_ff == ICW_KIND_MWDMA && mode_ff == 3'h4) ?
    ICW_ADV_MODE_B : ICW_ADV_OLDER;
  wire logic [15:0] w_adv = {4'h0, mw_sel, pio_sel, MW_MAX_ADV,
    PIO_MAX_ADV};

  wire logic [15:0] w_pc = {10'h000, PC_MEM_CODE, PC_IO_CODE};

  // identify word mux; unserved words read zero
  wire logic [15:0] word_mux =
    (wordsel_ff == ICW_W_UDMA) ? w_udma :
    (wordsel_ff == ICW_W_ERASE) ? {8'h00, erase_ff} :
    (wordsel_ff == ICW_W_EERASE) ? {8'h00, eerase_ff} :
    (wordsel_ff == ICW_W_APM) ? {8'h00, apm_ff} :
    (wordsel_ff == ICW_W_SEC) ? w_sec :
    (wordsel_ff == ICW_W_POWER) ? w_pow :
    (wordsel_ff == ICW_W_KEY) ? {15'h0, KEY_SCHEME} :
    (wordsel_ff == ICW_W_ADVIDE) ? w_adv :
    (wordsel_ff == ICW_W_PCCARD) ? w_pc : 16'h0000;

  // security command verdict: bit0 accepted, bit1 aborted
  wire logic [1:0] cmd = av_req.writedata[1:0];
  wire logic cmd_guarded = (cmd == ICW_CMD_UNLOCK) || (cmd == ICW_CMD_ERASE);
  wire logic cmd_abort = cmd_guarded & sec_ff[ICW_SC_EXPIRE];

  wire logic [31:0] nxt_rdata =
    (av_req.address == ICW_A_WORDSEL) ? {24'h000000, wordsel_ff} :
    (av_req.address == ICW_A_WORDDATA) ? {16'h0000, word_mux} :
    (av_req.address == ICW_A_XFER) ? {26'h0, kind_ff, 1'b0, mode_ff} :
    (av_req.address == ICW_A_SEC) ? {27'h0, sec_ff} :
    (av_req.address == ICW_A_APM) ? {24'h000000, apm_ff} :
    (av_req.address == ICW_A_STAT) ? {30'h0, verdict_ff} :
    (av_req.address == ICW_A_CAP) ? {4'h0, cur_ff, eerase_ff, erase_ff} :
    32'h00000000;

  // bus handshake and read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= take;
      if (take && av_req.read) rdata_ff <= nxt_rdata;
    end
  end

  // write strobes, one per writable register offset
  wire logic wr_wordsel = do_wr && (av_req.address == ICW_A_WORDSEL);
  wire logic wr_xfer = do_wr && (av_req.address == ICW_A_XFER) && wr_mode_ok;
  wire logic wr_apm = do_wr && (av_req.address == ICW_A_APM);
  wire logic wr_cap = do_wr && (av_req.address == ICW_A_CAP);
  wire logic wr_sec = do_wr && (av_req.address == ICW_A_SEC);
  wire logic wr_cmd = do_wr && (av_req.address == ICW_A_CMD);

  // next values; a refused mode write leaves the old selection standing
  wire logic [7:0] nxt_wordsel = wr_wordsel ? av_req.writedata[7:0] : wordsel_ff;
  wire logic [1:0] nxt_kind = wr_xfer ? wr_kind : kind_ff;
  wire logic [2:0] nxt_mode = wr_xfer ? wr_mode : mode_ff;
  wire logic [7:0] nxt_apm = wr_apm ? av_req.writedata[7:0] : apm_ff;
  wire logic [7:0] nxt_erase = wr_cap ? av_req.writedata[7:0] : erase_ff;
  wire logic [7:0] nxt_eerase = wr_cap ? av_req.writedata[15:8] : eerase_ff;
  wire logic [11:0] nxt_cur = wr_cap ? av_req.writedata[27:16] : cur_ff;

  // expire only sets: a clearing write must not reopen unlock attempts
  wire logic nxt_expire = sec_ff[ICW_SC_EXPIRE] |
    (wr_sec & av_req.writedata[ICW_SC_EXPIRE]);
  wire logic [3:0] nxt_sec_lo = wr_sec ? av_req.writedata[3:0] : sec_ff[3:0];
  wire logic [1:0] nxt_verdict = wr_cmd ? {cmd_abort, ~cmd_abort} : verdict_ff;

  // identify word pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wordsel_ff <= 8'h00;
    end else begin
      wordsel_ff <= nxt_wordsel;
    end
  end

  // transfer mode selection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      kind_ff <= ICW_KIND_PIO;
      mode_ff <= 3'h0;
    end else begin
      kind_ff <= nxt_kind;
      mode_ff <= nxt_mode;
    end
  end

  // power management level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      apm_ff <= ICW_APM_RST;
    end else begin
      apm_ff <= nxt_apm;
    end
  end

  // erase times and maximum current
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      erase_ff <= ICW_ERASE_RST;
      eerase_ff <= ICW_ERASE_RST;
      cur_ff <= ICW_CUR_RST;
    end else begin
      erase_ff <= nxt_erase;
      eerase_ff <= nxt_eerase;
      cur_ff <= nxt_cur;
    end
  end

  // security state; only reset clears expire
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_ff <= 5'h00;
    end else begin
      sec_ff <= {nxt_expire, nxt_sec_lo};
    end
  end

  // verdict of the last checked security command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      verdict_ff <= 2'b00;
    end else begin
      verdict_ff <= nxt_verdict;
    end
  end

  // udma selection one-hot and never alongside mwdma
  a_dma_one_sel: assert property (@(posedge clk) disable iff (!rstn)
    $onehot0(udma_sel) && !(udma_sel != 6'h00 && mw_sel != ICW_ADV_OLDER))
    else $error("two dma modes selected");

  // selected udma mode lands on its own bit
  a_udma_sel_bit: assert property (@(posedge clk) disable iff (!rstn)
    (kind_ff == ICW_KIND_UDMA) |-> udma_sel[mode_ff])
    else $error("udma select bit wrong");

  // support flags fill from bit 0 upwards
  a_udma_cumul: assert property (@(posedge clk) disable iff (!rstn)
    ((udma_sup + 6'h01) & udma_sup) == 6'h00)
    else $error("udma support not cumulative");

  // word 88 carries mode 0 support whenever any udma mode exists
  a_udma_present: assert property (@(posedge clk) disable iff (!rstn)
    (UDMA_MAX >= 0) |-> w_udma[0])
    else $error("udma word missing");

  // erase time word passes the stored code unchanged
  a_erase_word: assert property (@(posedge clk) disable iff (!rstn)
    (wordsel_ff == ICW_W_ERASE) |-> word_mux == {8'h00, erase_ff})
    else $error("erase time word wrong");

  // enhanced erase time uses the same code
  a_eerase_word: assert property (@(posedge clk) disable iff (!rstn)
    (wordsel_ff == ICW_W_EERASE) |-> word_mux == {8'h00, eerase_ff})
    else $error("enhanced erase time word wrong");

  // apm word shows the current level, upper byte zero
  a_apm_word: assert property (@(posedge clk) disable iff (!rstn)
    (wordsel_ff == ICW_W_APM) |-> word_mux == {8'h00, apm_ff})
    else $error("apm word wrong");

  // apm register follows every write
  a_apm_track: assert property (@(posedge clk) disable iff (!rstn)
    wr_apm |=> apm_ff == $past(av_req.writedata[7:0]))
    else $error("apm level stale");

  // maximum level only with security enabled
  a_max_level: assert property (@(posedge clk) disable iff (!rstn)
    w_sec[8] |-> w_sec[1])
    else $error("max level without enable");

  // expire stays up for at least eight cycles
  a_expire_sticky: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sec_ff[ICW_SC_EXPIRE]) |-> sec_ff[ICW_SC_EXPIRE] [*8])
    else $error("expire cleared");

  // guarded commands abort once expired
  a_expire_abort: assert property (@(posedge clk) disable iff (!rstn)
    (do_wr && av_req.address == ICW_A_CMD && cmd_guarded &&
    sec_ff[ICW_SC_EXPIRE]) |=> verdict_ff == 2'b10)
    else $error("command not aborted");

  // anything not aborted is reported accepted
  a_verdict_ok: assert property (@(posedge clk) disable iff (!rstn)
    (wr_cmd && !cmd_abort) |=> verdict_ff == 2'b01)
    else $error("command wrongly aborted");

  // expire bit of the status word mirrors the sticky flag
  a_expire_bit: assert property (@(posedge clk) disable iff (!rstn)
    w_sec[4] == sec_ff[ICW_SC_EXPIRE])
    else $error("expire bit wrong");

  // status bits sit where the host looks for them
  a_sec_bits: assert property (@(posedge clk) disable iff (!rstn)
    w_sec[0] && w_sec[1] == sec_ff[ICW_SC_EN] && w_sec[2] == sec_ff[ICW_SC_LOCK] &&
    w_sec[3] == sec_ff[ICW_SC_FROZEN] && w_sec[5] == ENH_ERASE)
    else $error("security status bits wrong");

  // power word valid with the stored current
  a_power_word: assert property (@(posedge clk) disable iff (!rstn)
    w_pow[15] && w_pow[11:0] == cur_ff)
    else $error("power word wrong");

  // absent level 1 commands also read disabled
  a_level1_dis: assert property (@(posedge clk) disable iff (!rstn)
    w_pow[13] == LEVEL1_ABSENT && (!w_pow[13] || w_pow[12]))
    else $error("level 1 command bits wrong");

  // capability writes land in all three fields
  a_cap_track: assert property (@(posedge clk) disable iff (!rstn)
    wr_cap |=> {cur_ff, eerase_ff, erase_ff} == $past(av_req.writedata[27:0]))
    else $error("capability write lost");

  // key word: scheme flag only
  a_key_word: assert property (@(posedge clk) disable iff (!rstn)
    (wordsel_ff == ICW_W_KEY) |-> word_mux == {15'h0, KEY_SCHEME})
    else $error("key word wrong");

  // advanced maxima come straight from the build
  a_adv_max: assert property (@(posedge clk) disable iff (!rstn)
    w_adv[2:0] == PIO_MAX_ADV && w_adv[5:3] == MW_MAX_ADV)
    else $error("advanced maximum wrong");

  // pio mode 6 selected reads code 2
  a_pio_sel: assert property (@(posedge clk) disable iff (!rstn)
    (kind_ff == ICW_KIND_PIO && mode_ff == 3'h6) |-> w_adv[8:6] == ICW_ADV_MODE_B)
    else $error("pio selection wrong");

  // no mwdma selection unless mwdma is the kind
  a_mw_sel: assert property (@(posedge clk) disable iff (!rstn)
    (kind_ff != ICW_KIND_MWDMA) |-> w_adv[11:9] == ICW_ADV_OLDER)
    else $error("mwdma selection wrong");

  // pc card cycle codes from the build
  a_pc_codes: assert property (@(posedge clk) disable iff (!rstn)
    w_pc[2:0] == PC_IO_CODE && w_pc[5:3] == PC_MEM_CODE)
    else $error("pc card codes wrong");

  // reserved bits of the power, advanced timing and pc card words stay low
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
    w_pow[14] == 1'b0 && w_adv[15:12] == 4'h0 && w_pc[15:6] == 10'h000)
    else $error("reserved bit set");

  // accepted mode writes show up next cycle
  a_xfer_track: assert property (@(posedge clk) disable iff (!rstn)
    wr_xfer |=> kind_ff == $past(wr_kind) && mode_ff == $past(wr_mode))
    else $error("mode selection stale");

  // refused mode writes keep one valid selection
  a_xfer_refuse: assert property (@(posedge clk) disable iff (!rstn)
    (do_wr && av_req.address == ICW_A_XFER && !wr_mode_ok) |=>
    $stable(kind_ff) && $stable(mode_ff))
    else $error("refused mode taken");

  // words outside the served range read zero
  a_unserved_zero: assert property (@(posedge clk) disable iff (!rstn)
    (wordsel_ff < ICW_W_UDMA || wordsel_ff > ICW_W_PCCARD) |-> word_mux == 16'h0000)
    else $error("unserved word not zero");

  // exactly one wait cycle per access
  a_bus_answer: assert property (@(posedge clk) disable iff (!rstn)
    (req && av_waitrequest) |=> !av_waitrequest)
    else $error("no answer in one cycle");

  // idle bus never stalls
  a_idle_nowait: assert property (@(posedge clk) disable iff (!rstn)
    !req |-> !av_waitrequest)
    else $error("waitrequest while idle");

  // read data stands until the next read is taken
  a_rdata_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(take && av_req.read) |=> $stable(av_readdata))
    else $error("read data moved");

  // main scenarios reached
  c_udma_pick: cover property (@(posedge clk) disable iff (!rstn)
    kind_ff == ICW_KIND_UDMA && mode_ff == 3'h5);
  c_mw_pick: cover property (@(posedge clk) disable iff (!rstn)
    mw_sel == ICW_ADV_MODE_B);
  c_pio_six: cover property (@(posedge clk) disable iff (!rstn)
    pio_sel == ICW_ADV_MODE_B);
  c_expire_set: cover property (@(posedge clk) disable iff (!rstn)
    $rose(sec_ff[ICW_SC_EXPIRE]));
  c_abort: cover property (@(posedge clk) disable iff (!rstn)
    verdict_ff == 2'b10);
endmodule : icw_identify_words
`default_nettype wire

// >>> verif/icw_host_model.sv
/*
  host side model: an avalon-mm master that reads identify words.
  assumes the slave answers by dropping waitrequest; no fixed latency.
*/
`timescale 1ns/100ps
`default_nettype none
module icw_host_model
  import icw_pkg::*;
(
  input wire logic clk,
  output var icw_av_req_type av_req,
  input wire logic av_waitrequest,
  input wire logic [31:0] av_readdata
);
  initial av_req = '0;
  // one access; starts a cycle late so no signal is assigned twice in one step
  task automatic access(input logic is_wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    icw_av_req_type r;
    r = '0;
    r.address = a;
    r.write = is_wr;
    r.read = !is_wr;
    r.writedata = d;
    @(posedge clk);
    av_req <= r;
    // waitrequest is looked at on the rising edge only; the request stands till then
    do @(posedge clk); while (av_waitrequest !== 1'b0);
    q = av_readdata; // taken at the completing edge
    av_req <= '0;
  endtask : access
endmodule : icw_host_model
`default_nettype wire

// >>> verif/icw_identify_words_tb_top.sv
/*
  self-checking bench for the identify capability words block.
  assumes default parameters and the host model as avalon master.
*/
`timescale 1ns/100ps
`default_nettype none
module icw_identify_words_tb_top
  import icw_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  icw_av_req_type av_req;
  logic av_waitrequest;
  logic [31:0] av_readdata;
  int errors = 0;
  int checks = 0;
  logic [31:0] lfsr = 32'h806a2a8d;
  logic [31:0] q;
  logic [1:0] m_kind;
  logic [2:0] m_mode;
  logic [4:0] m_sec;
  logic [7:0] m_apm;
  logic [27:0] m_cap;
  logic [7:0] wl [9] = '{ICW_W_UDMA, ICW_W_ERASE, ICW_W_EERASE, ICW_W_APM, ICW_W_SEC,
                         ICW_W_POWER, ICW_W_KEY, ICW_W_ADVIDE, ICW_W_PCCARD};
  always #5 clk = ~clk;
  icw_identify_words dut_u (.clk(clk), .rstn(rstn), .av_req(av_req),
    .av_waitrequest(av_waitrequest), .av_readdata(av_readdata));
  icw_host_model host_u (.clk(clk), .av_req(av_req), .av_waitrequest(av_waitrequest),
    .av_readdata(av_readdata));
  // galois lfsr, fixed seed keeps runs repeatable
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction : step
  // expected identify word from the mirrored state
  function automatic logic [15:0] exp_word(input logic [7:0] w);
    logic [5:0] usel;
    logic [2:0] psel;
    logic [2:0] msel;
    usel = (m_kind == ICW_KIND_UDMA) ? 6'h01 << m_mode : 6'h00;
    psel = (m_kind == ICW_KIND_PIO) ? {1'b0, m_mode == 3'h6, m_mode == 3'h5} : 3'h0;
    msel = (m_kind == ICW_KIND_MWDMA) ? {1'b0, m_mode == 3'h4, m_mode == 3'h3} : 3'h0;
    case (w)
      ICW_W_UDMA: return {2'h0, usel, 2'h0, 6'h3f};
      ICW_W_ERASE: return {8'h0, m_cap[7:0]};
      ICW_W_EERASE: return {8'h0, m_cap[15:8]};
      ICW_W_APM: return {8'h0, m_apm};
      ICW_W_SEC: return {7'h0, m_sec[0] & m_sec[3], 2'h0, 1'b1, m_sec[4], m_sec[2:0], 1'b1};
      ICW_W_POWER: return {4'hb, m_cap[27:16]};
      ICW_W_ADVIDE: return {4'h0, msel, psel, 6'h12};
      ICW_W_PCCARD: return 16'h001b;
      default: return 16'h0000;
    endcase
  endfunction : exp_word
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    host_u.access(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    host_u.access(1'b0, a, 32'h0, q);
  endtask : rd
  // mirror follows reset values
  task automatic mreset();
    m_kind = ICW_KIND_PIO;
    m_mode = 3'h0;
    m_sec = 5'h00;
    m_apm = ICW_APM_RST;
    m_cap = {ICW_CUR_RST, ICW_ERASE_RST, ICW_ERASE_RST};
  endtask : mreset
  task automatic all_words();
    for (int i = 0; i < 9; i++) begin
      wr(ICW_A_WORDSEL, {24'h0, wl[i]});
      rd(ICW_A_WORDDATA);
      chk($sformatf("word %h", wl[i]), {16'h0, exp_word(wl[i])}, q);
    end
  endtask : all_words
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // watchdog, far beyond the few thousand cycles the run needs
  initial begin
    #400000;
    errors++;
    close_out();
  end
  initial begin
    logic ok;
    mreset();
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    all_words();
    for (int i = 0; i < 30; i++) begin
      lfsr = step(lfsr);
      wr(ICW_A_XFER, {26'h0, lfsr[5:4], 1'b0, lfsr[2:0]});
      ok = lfsr[5:4] == ICW_KIND_PIO || (lfsr[5:4] == ICW_KIND_UDMA && lfsr[2:0] <= 3'h5)
           || (lfsr[5:4] == ICW_KIND_MWDMA && lfsr[2:0] <= 3'h4);
      if (ok) {m_kind, m_mode} = {lfsr[5:4], lfsr[2:0]};
      wr(ICW_A_SEC, {28'h0, lfsr[11:8]});
      m_sec[3:0] = lfsr[11:8];
      m_apm = lfsr[23:16];
      wr(ICW_A_APM, {24'h0, m_apm});
      lfsr = step(lfsr);
      m_cap = (i == 0) ? 28'hffffe01 : (i == 1) ? 28'h00000ff : lfsr[27:0];
      wr(ICW_A_CAP, {4'h0, m_cap});
      all_words();
    end
    for (int a = 8; a < 16; a++) begin
      rd(a[3:0]);
      chk("unmapped", 32'h0, q);
    end
    // guarded commands abort only once the attempt count has expired
    for (int e = 0; e < 2; e++) begin
      if (e == 1) wr(ICW_A_SEC, 32'h10);
      if (e == 1) m_sec = 5'h10;
      for (int c = 0; c < 4; c++) begin
        wr(ICW_A_CMD, c);
        rd(ICW_A_STAT);
        ok = e == 1 && (c == 1 || c == 2);
        chk("verdict", {30'h0, ok, !ok}, q);
      end
      wr(ICW_A_SEC, 32'h0); // expire must survive a clearing write
      m_sec[3:0] = 4'h0;
      all_words();
    end
    // a second reset is the only way out of the expired state
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    mreset();
    all_words();
    close_out();
  end
endmodule : icw_identify_words_tb_top
`default_nettype wire
